// ===== hdl/alu_status_flags.sv
// Status word of the 8-bit core: result flags, user flags, bank select, parity
//
// Summary of operation
// - carry bit 7 set by arithmetic carry out
// - carry is the Boolean bit accumulator
// - half-carry bit 6 from low nibble carry
// - bit 5 user flag, software only
// - bits 4..3 select the working register bank
// - overflow bit 2 is carry6 xor carry7
// - bit 1 second user flag, software only
// - parity bit 0 tracks accumulator continuously
`default_nettype none
module alu_status_flags
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	// Core side
	input wire logic [7:0] accumulator,
	input wire logic alu_update,
	input wire status_word_pkg::alu_flags_t alu_flags,
	input wire logic bit_op_write,
	input wire logic bit_op_result,
	output logic bit_op_operand,
	output logic [1:0] bank_select,
	output logic [7:0] bank_base,
	output logic [7:0] status_word,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	////////////////////////////////////////////////////////////////////////////
	// Bus write side: address and data captured independently
	logic aw_held_q, w_held_q;
	logic [7:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	wire aw_take = s_awvalid && !aw_held_q && !bvalid_q;
	wire w_take = s_wvalid && !w_held_q && !bvalid_q;
	wire wr_fire = aw_held_q && w_held_q;
	wire wr_hit = awaddr_q[7:2] == status_word_pkg::program_status_word_offset[7:2];
	wire sw_write = wr_fire && wr_hit && wstrb0_q;
	assign s_awready = !aw_held_q && !bvalid_q;
	assign s_wready = !w_held_q && !bvalid_q;
	assign s_bvalid = bvalid_q;
	assign s_bresp = bresp_q;

	// Write channel holding registers and response
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= status_word_pkg::resp_okay;
		end
		else if (clk_en)
		begin
			if (aw_take)
			begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end
			if (w_take)
			begin
				w_held_q <= 1'b1;
				wdata_q <= s_wdata[7:0];
				wstrb0_q <= s_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? status_word_pkg::resp_okay : status_word_pkg::resp_slverr;
			end
			else if (bvalid_q && s_bready)
				bvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status word storage
	logic carry_q, half_carry_q, user_a_q, overflow_q, user_b_q;
	logic [1:0] bank_q;
	// Parity is an XOR tree, never stored, so it can't go stale
	wire parity = ^accumulator;
	wire [7:0] status_d = {carry_q, half_carry_q, user_a_q, bank_q, overflow_q, user_b_q, parity};

	// Software write first, then the ALU; the ALU result wins a same-cycle clash
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			carry_q <= status_word_pkg::program_status_word_reset[status_word_pkg::carry_pos];
			half_carry_q <= status_word_pkg::program_status_word_reset[status_word_pkg::half_carry_pos];
			user_a_q <= status_word_pkg::program_status_word_reset[status_word_pkg::user_a_pos];
			bank_q <= status_word_pkg::program_status_word_reset[status_word_pkg::bank_high_pos:status_word_pkg::bank_low_pos];
			overflow_q <= status_word_pkg::program_status_word_reset[status_word_pkg::overflow_pos];
			user_b_q <= status_word_pkg::program_status_word_reset[status_word_pkg::user_b_pos];
		end
		else if (clk_en)
		begin
			if (sw_write)
			begin
				carry_q <= wdata_q[status_word_pkg::carry_pos];
				half_carry_q <= wdata_q[status_word_pkg::half_carry_pos];
				user_a_q <= wdata_q[status_word_pkg::user_a_pos];
				bank_q <= wdata_q[status_word_pkg::bank_high_pos:status_word_pkg::bank_low_pos];
				overflow_q <= wdata_q[status_word_pkg::overflow_pos];
				user_b_q <= wdata_q[status_word_pkg::user_b_pos];
			end
			if (alu_update)
			begin
				carry_q <= alu_flags.carry;
				half_carry_q <= alu_flags.half_carry;
				overflow_q <= alu_flags.overflow;
			end
			else if (bit_op_write)
				carry_q <= bit_op_result;
		end
	end

	// Core-facing views of the word
	assign bit_op_operand = carry_q;
	assign bank_select = bank_q;
	assign bank_base = 8'(bank_q) * 8'(status_word_pkg::bank_regs);
	assign status_word = status_d;

	////////////////////////////////////////////////////////////////////////////
	// Bus read side: one cycle from address to data
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire rd_hit = s_araddr[7:2] == status_word_pkg::program_status_word_offset[7:2];
	assign s_arready = !rvalid_q;
	assign s_rvalid = rvalid_q;
	assign s_rdata = rdata_q;
	assign s_rresp = rresp_q;

	// Read data register
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= status_word_pkg::resp_okay;
		end
		else if (clk_en)
		begin
			if (s_arvalid && !rvalid_q)
			begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_hit ? {24'h00_0000, status_d} : 32'h0000_0000;
				rresp_q <= rd_hit ? status_word_pkg::resp_okay : status_word_pkg::resp_slverr;
			end
			else if (rvalid_q && s_rready)
				rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence alu_step_s;
		clk_en && alu_update;
	endsequence

	carry_from_alu_a: assert property (@(posedge mclk) disable iff (reset)
		alu_step_s |=> status_word[7] == $past(alu_flags.carry))
		else $error("carry not taken from ALU");
	bit_acc_a: assert property (@(posedge mclk) disable iff (reset)
		clk_en && bit_op_write && !alu_update |=> bit_op_operand == $past(bit_op_result))
		else $error("bit result not in carry");
	half_carry_a: assert property (@(posedge mclk) disable iff (reset)
		alu_step_s |=> status_word[6] == $past(alu_flags.half_carry))
		else $error("half carry wrong");
	user_a_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!(clk_en && sw_write) |=> $stable(status_word[5]))
		else $error("user flag a changed without write");
	bank_map_a: assert property (@(posedge mclk) disable iff (reset)
		clk_en && sw_write |=> bank_select == $past(wdata_q[4:3]))
		else $error("bank select not written");
	overflow_a: assert property (@(posedge mclk) disable iff (reset)
		alu_step_s |=> status_word[2] == $past(alu_flags.overflow))
		else $error("overflow wrong");
	user_b_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!(clk_en && sw_write) |=> $stable(status_word[1]))
		else $error("user flag b changed without write");
	parity_track_a: assert property (@(posedge mclk) disable iff (reset)
		status_word[0] == (($countones(accumulator) % 2) != 0))
		else $error("parity does not follow accumulator");
	parity_odd_a: assert property (@(posedge mclk) disable iff (reset)
		(($countones(accumulator) % 2) == 1) |-> status_word[0])
		else $error("parity not one for odd count");
	bank_base_a: assert property (@(posedge mclk) disable iff (reset)
		bank_base == {3'h0, bank_select, 3'h0})
		else $error("bank base address wrong");
endmodule
`default_nettype wire

// ===== hdl/status_word_pkg.sv
// Package with the status word layout, offsets and reset values
`default_nettype none
package status_word_pkg;
	// Byte address of the status word on the register bus
	localparam logic [7:0] program_status_word_offset = 8'hd0;
	localparam logic [7:0] program_status_word_reset = 8'h00;
	// Bit positions within the word
	localparam int carry_pos = 7;
	localparam int half_carry_pos = 6;
	localparam int user_a_pos = 5;
	localparam int bank_high_pos = 4;
	localparam int bank_low_pos = 3;
	localparam int overflow_pos = 2;
	localparam int user_b_pos = 1;
	localparam int parity_pos = 0;
	// Working registers per bank
	localparam int bank_regs = 8;
	// Bus response codes
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// Result flags that the arithmetic unit hands over
	typedef struct packed {
		logic carry;
		logic half_carry;
		logic overflow;
	} alu_flags_t;
endpackage
`default_nettype wire

// ===== test/alu_status_flags_tb_top.sv
// Self-checking bench for the status word block
`default_nettype none
module alu_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0;
	logic reset = 1'h1;
	logic clk_en = 1'h1;
	logic [7:0] accumulator = 8'h07;
	logic alu_update = 1'h0;
	status_word_pkg::alu_flags_t alu_flags = 3'h0;
	logic bit_op_write = 1'h0;
	logic bit_op_result = 1'h0;
	logic bit_op_operand;
	logic [1:0] bank_select;
	logic [7:0] bank_base;
	logic [7:0] status_word;
	logic [7:0] s_awaddr = 8'h00;
	logic [7:0] s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0;
	logic [31:0] s_rdata;
	logic [3:0] s_wstrb = 4'h1;
	logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp;
	logic [1:0] s_rresp;
	logic [31:0] rd_data;
	logic [1:0] rs;
	int err_count = 0;
	int total_checks = 0;

	// 100 MHz core clock
	always #5 mclk = ~mclk;
	alu_status_flags dut_u
	(
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.accumulator(accumulator),
		.alu_update(alu_update),
		.alu_flags(alu_flags),
		.bit_op_write(bit_op_write),
		.bit_op_result(bit_op_result),
		.bit_op_operand(bit_op_operand),
		.bank_select(bank_select),
		.bank_base(bank_base),
		.status_word(status_word),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready)
	);

	////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus write; both channels offered together, bready held until the answer
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge mclk);
			if (s_awready)
				s_awvalid <= 1'h0;
			if (s_wready)
				s_wvalid <= 1'h0;
			if (s_bvalid)
				break;
		end
		s_bready <= 1'h0;
		rs = s_bresp;
		// One idle edge so a following call never reassigns bready in this step
		@(posedge mclk);
		if (n == 20)
		begin
			err_count++;
			results;
		end
	endtask

	// Bus read; a stuck slave ends the run through the bound
	task rd(input logic [7:0] a);
		int n;
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge mclk);
			if (s_arready)
				s_arvalid <= 1'h0;
			if (s_rvalid)
				break;
		end
		s_rready <= 1'h0;
		rd_data = s_rdata;
		rs = s_rresp;
		// One idle edge so a following call never reassigns rready in this step
		@(posedge mclk);
		if (n == 20)
		begin
			err_count++;
			results;
		end
	endtask

	// One core cycle of flag traffic, then one idle edge so updates have landed
	task core(input logic a, input logic b, input logic r, input logic [2:0] f);
		alu_update <= a;
		bit_op_write <= b;
		bit_op_result <= r;
		alu_flags <= f;
		@(posedge mclk);
		alu_update <= 1'h0;
		bit_op_write <= 1'h0;
		@(posedge mclk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (20) @(posedge mclk);
		reset <= 1'h0;
		@(posedge mclk);
		rd(8'hd0);
		chk(rd_data, 32'h1);
		wr(8'hd0, 32'hf8);
		chk(32'(status_word), 32'hf9);
		chk(32'(bank_base), 32'h18);
		chk(32'(bank_select), 32'h3);
		chk(32'(bit_op_operand), 32'h1);
		accumulator <= 8'h03;
		wr(8'hd0, 32'h0b);
		chk(32'(status_word), 32'h0a);
		chk(32'(bank_base), 32'h08);
		core(1'h1, 1'h0, 1'h0, 3'h7);
		chk(32'(status_word), 32'hce);
		core(1'h0, 1'h1, 1'h0, 3'h7);
		chk(32'(status_word), 32'h4e);
		chk(32'(bit_op_operand), 32'h0);
		core(1'h1, 1'h1, 1'h1, 3'h0);
		chk(32'(status_word), 32'h0a);
		wr(8'h04, 32'hff);
		chk(32'(rs), 32'(status_word_pkg::resp_slverr));
		chk(32'(status_word), 32'h0a);
		rd(8'h04);
		chk(32'(rs), 32'(status_word_pkg::resp_slverr));
		chk(rd_data, 32'h0);
		accumulator <= 8'h80;
		rd(8'hd0);
		chk(rd_data, 32'h0b);
		chk(32'(rs), 32'(status_word_pkg::resp_okay));
		// Clock enable low: no flag may move
		clk_en <= 1'h0;
		core(1'h1, 1'h1, 1'h1, 3'h7);
		chk(32'(status_word), 32'h0b);
		clk_en <= 1'h1;
		// Byte lane 0 off: answered OKAY but the word keeps its value
		s_wstrb <= 4'h0;
		wr(8'hd0, 32'hf4);
		chk(32'(rs), 32'(status_word_pkg::resp_okay));
		chk(32'(status_word), 32'h0b);
		s_wstrb <= 4'h1;
		// Second reset in mid-run clears all stored flags
		reset <= 1'h1;
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		@(posedge mclk);
		chk(32'(status_word), 32'h01);
		chk(32'(bank_base), 32'h00);
		results;
	end
endmodule
`default_nettype wire
